/* File: common/spt_map.svh */
`ifndef SPT_MAP_SVH
`define SPT_MAP_SVH

// bits per transfer
`define SPT_BITS       8
// system clock period and serial clock half period
`define SPT_SYS_NS     5
`define SPT_HALF_NS    40
// least time, rounded up to whole system cycles
`define SPT_HALF_CYC   ((`SPT_HALF_NS + `SPT_SYS_NS - 1) / `SPT_SYS_NS)
// transmit buffer
`define SPT_FIFO_DEPTH 4
// reset values of the link lines
`define SPT_RST_SS_N   1'b1
`define SPT_RST_MOSI   1'b0

`endif

/* File: common/spt_pkg.sv */
`include "spt_map.svh"

package spt_pkg;

   typedef logic [`SPT_BITS-1:0] spt_byte_t;

   typedef enum logic [2:0]
   {
      SPT_M_IDLE  = 3'h0,
      SPT_M_SETUP = 3'h1,
      SPT_M_SHIFT = 3'h2,
      SPT_M_HOLD  = 3'h3,
      SPT_M_DESEL = 3'h4
   } spt_mst_state_t;

   typedef enum logic [1:0]
   {
      SPT_S_IDLE   = 2'h0,
      SPT_S_ACTIVE = 2'h1,
      SPT_S_DONE   = 2'h2
   } spt_slv_state_t;

endpackage : spt_pkg

/* File: common/spt_if.sv */
`timescale 1ns/1ps

interface spt_if;
   logic sclk;
   logic mosi;
   logic ss_n;
   logic miso_d;
   logic miso_oe_n;
   wire  miso;

   // -----------------------------------------------------------------
   // miso wire: pulled high while no slave drives it
   // -----------------------------------------------------------------
   assign miso = miso_oe_n ? 1'b1 : miso_d;

   modport master
   (
      output sclk,
      output mosi,
      output ss_n,
      input  miso
   );

   modport slave
   (
      input  sclk,
      input  mosi,
      input  ss_n,
      output miso_d,
      output miso_oe_n
   );
endinterface : spt_if

/* File: design/spt_master.sv */
`timescale 1ns/1ps
`include "spt_map.svh"

module spt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             CLK_SYS_I,
   input  wire logic             RESETN_I,
   input  wire logic             IN_VALID_I,
   output      logic             IN_READY_O,
   input  wire logic [WIDTH-1:0] IN_DATA_I,
   output      logic             OUT_VALID_O,
   input  wire logic             OUT_READY_I,
   output      logic [WIDTH-1:0] OUT_DATA_O
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign IN_READY_O  = (count != DEPTH[AW:0]);
   assign OUT_VALID_O = (count != '0);
   assign OUT_DATA_O  = mem[rd_ptr];
   assign push        = IN_VALID_I & IN_READY_O;
   assign pop         = OUT_VALID_O & OUT_READY_I;

   always_comb
   begin
      next_mem    = mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push)
      begin
         next_mem[wr_ptr] = IN_DATA_I;
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RESETN_I)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      mem <= next_mem;
   end
endmodule : spt_fifo

// Operation
// - slave drives miso only while selected
// - master's own select stays high
// - phase 0: first clock edge samples msb
// - phase 0: select fall starts, msb first
// - phase 0: master toggles select between bytes
// - phase 1: master drives mosi on first edge
// - phase 1: slave starts on first edge
// - phase 1: select may stay low between bytes
// - both phases work with either polarity
// - miso from slave, mosi from master only
module spt_master
(
   input  wire logic                CLK_SYS_I,
   input  wire logic                RESETN_I,
   spt_if.master                    link,
   input  wire logic                CPOL_I,
   input  wire logic                CPHA_I,
   input  wire logic                HOLD_SS_I,
   input  wire logic                OWN_SS_N_I,
   input  wire logic                TX_VALID_I,
   output      logic                TX_READY_O,
   input  wire spt_pkg::spt_byte_t  TX_DATA_I,
   output      spt_pkg::spt_byte_t  RX_DATA_O,
   output      logic                RX_VALID_O,
   output      logic                BUSY_O,
   output      logic                MODE_FAULT_O
);
   localparam logic [3:0] HALF_LAST = 4'(`SPT_HALF_CYC - 1);

   spt_pkg::spt_mst_state_t state;
   spt_pkg::spt_mst_state_t next_state;
   logic [3:0]              cnt;
   logic [3:0]              next_cnt;
   logic [4:0]              edges;
   logic [4:0]              next_edges;
   spt_pkg::spt_byte_t      sh_tx;
   spt_pkg::spt_byte_t      next_sh_tx;
   spt_pkg::spt_byte_t      sh_rx;
   spt_pkg::spt_byte_t      next_sh_rx;
   spt_pkg::spt_byte_t      next_rx_data;
   logic                    next_rx_valid;
   logic                    sclk;
   logic                    next_sclk;
   logic                    mosi;
   logic                    next_mosi;
   logic                    ss_n;
   logic                    next_ss_n;
   logic                    cpol;
   logic                    next_cpol;
   logic                    cpha;
   logic                    next_cpha;
   logic [1:0]              miso_sync;
   logic [1:0]              ss_sync;
   logic                    half_done;
   logic                    lead;
   logic                    q_valid;
   logic                    q_pop;
   spt_pkg::spt_byte_t      q_data;

   // -----------------------------------------------------------------
   // transmit buffer: a full queue stalls the user side
   // -----------------------------------------------------------------
   spt_fifo #(
      .WIDTH (`SPT_BITS),
      .DEPTH (`SPT_FIFO_DEPTH)
   ) u_fifo (
      .CLK_SYS_I   (CLK_SYS_I),
      .RESETN_I    (RESETN_I),
      .IN_VALID_I  (TX_VALID_I),
      .IN_READY_O  (TX_READY_O),
      .IN_DATA_I   (TX_DATA_I),
      .OUT_VALID_O (q_valid),
      .OUT_READY_I (q_pop),
      .OUT_DATA_O  (q_data)
   );

   assign link.sclk    = sclk;
   assign link.mosi    = mosi;
   assign link.ss_n    = ss_n;
   assign half_done    = (cnt == HALF_LAST);
   assign lead         = ~edges[0];
   assign q_pop        = (state == spt_pkg::SPT_M_IDLE) & q_valid;
   assign BUSY_O       = (state != spt_pkg::SPT_M_IDLE);
   // own select pulled low while busy means a second master exists
   assign MODE_FAULT_O = BUSY_O & ~ss_sync[1];

   // -----------------------------------------------------------------
   // transfer sequencer
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state    = state;
      next_cnt      = half_done ? 4'h0 : cnt + 4'h1;
      next_edges    = edges;
      next_sh_tx    = sh_tx;
      next_sh_rx    = sh_rx;
      next_rx_data  = RX_DATA_O;
      next_rx_valid = 1'b0;
      next_sclk     = sclk;
      next_mosi     = mosi;
      next_ss_n     = ss_n;
      next_cpol     = cpol;
      next_cpha     = cpha;
      case (state)
         spt_pkg::SPT_M_IDLE:
         begin
            next_cnt = 4'h0;
            if (q_valid)
            begin
               next_cpol  = CPOL_I;
               next_cpha  = CPHA_I;
               next_sclk  = CPOL_I;
               next_ss_n  = 1'b0;
               next_edges = 5'h0;
               next_state = spt_pkg::SPT_M_SETUP;
               if (!CPHA_I)
               begin
                  next_mosi  = q_data[7];
                  next_sh_tx = {q_data[6:0], 1'b0};
               end
               else
               begin
                  next_sh_tx = q_data;
               end
            end
            else if (!ss_n && !HOLD_SS_I)
            begin
               next_ss_n  = 1'b1;
               next_state = spt_pkg::SPT_M_DESEL;
            end
            else if (ss_n)
            begin
               next_sclk = CPOL_I;
            end
         end
         spt_pkg::SPT_M_SETUP:
         begin
            if (half_done)
            begin
               next_state = spt_pkg::SPT_M_SHIFT;
            end
         end
         spt_pkg::SPT_M_SHIFT:
         begin
            if (half_done)
            begin
               next_sclk  = ~sclk;
               next_edges = edges + 5'h1;
               if (lead ^ cpha)
               begin
                  next_sh_rx = {sh_rx[6:0], miso_sync[1]};
               end
               else
               begin
                  next_mosi  = sh_tx[7];
                  next_sh_tx = {sh_tx[6:0], 1'b0};
               end
               if (edges == 5'h0F)
               begin
                  next_state = spt_pkg::SPT_M_HOLD;
               end
            end
         end
         spt_pkg::SPT_M_HOLD:
         begin
            if (half_done)
            begin
               next_rx_data  = sh_rx;
               next_rx_valid = 1'b1;
               if (!cpha || !HOLD_SS_I)
               begin
                  next_ss_n  = 1'b1;
                  next_state = spt_pkg::SPT_M_DESEL;
               end
               else
               begin
                  next_state = spt_pkg::SPT_M_IDLE;
               end
            end
         end
         spt_pkg::SPT_M_DESEL:
         begin
            if (half_done)
            begin
               next_state = spt_pkg::SPT_M_IDLE;
            end
         end
         default:
         begin
            next_state = spt_pkg::SPT_M_IDLE;
            next_ss_n  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RESETN_I)
      begin
         state      <= spt_pkg::SPT_M_IDLE;
         cnt        <= 4'h0;
         edges      <= 5'h0;
         sh_tx      <= 8'h00;
         sh_rx      <= 8'h00;
         RX_DATA_O  <= 8'h00;
         RX_VALID_O <= 1'b0;
         sclk       <= 1'b0;
         mosi       <= `SPT_RST_MOSI;
         ss_n       <= `SPT_RST_SS_N;
         cpol       <= 1'b0;
         cpha       <= 1'b0;
         miso_sync  <= 2'h0;
         ss_sync    <= 2'h3;
      end
      else
      begin
         state      <= next_state;
         cnt        <= next_cnt;
         edges      <= next_edges;
         sh_tx      <= next_sh_tx;
         sh_rx      <= next_sh_rx;
         RX_DATA_O  <= next_rx_data;
         RX_VALID_O <= next_rx_valid;
         sclk       <= next_sclk;
         mosi       <= next_mosi;
         ss_n       <= next_ss_n;
         cpol       <= next_cpol;
         cpha       <= next_cpha;
         miso_sync  <= {miso_sync[0], link.miso};
         ss_sync    <= {ss_sync[0], OWN_SS_N_I};
      end
   end
endmodule : spt_master

/* File: design/spt_slave.sv */
`timescale 1ns/1ps
`include "spt_map.svh"

module spt_slave
(
   input  wire logic                CLK_SYS_I,
   input  wire logic                RESETN_I,
   spt_if.slave                     link,
   input  wire logic                CPOL_I,
   input  wire logic                CPHA_I,
   input  wire spt_pkg::spt_byte_t  TX_DATA_I,
   output      logic                TX_TAKEN_O,
   output      spt_pkg::spt_byte_t  RX_DATA_O,
   output      logic                RX_VALID_O
);
   spt_pkg::spt_slv_state_t state;
   spt_pkg::spt_slv_state_t next_state;
   logic [2:0]              sync1;
   logic [2:0]              sync2;
   logic                    sclk_d;
   logic                    ss_d;
   logic [2:0]              bits;
   logic [2:0]              next_bits;
   spt_pkg::spt_byte_t      sh_tx;
   spt_pkg::spt_byte_t      next_sh_tx;
   spt_pkg::spt_byte_t      sh_rx;
   spt_pkg::spt_byte_t      next_sh_rx;
   spt_pkg::spt_byte_t      next_rx_data;
   logic                    next_rx_valid;
   logic                    next_tx_taken;
   logic                    miso;
   logic                    next_miso;
   logic                    sclk_now;
   logic                    mosi_now;
   logic                    ss_now;
   logic                    edge_seen;
   logic                    lead;
   logic                    sample;
   logic                    change;

   // -----------------------------------------------------------------
   // pin sampling: only the second stage feeds logic
   // -----------------------------------------------------------------
   assign sclk_now       = sync2[0];
   assign mosi_now       = sync2[1];
   assign ss_now         = sync2[2];
   assign edge_seen      = sclk_now ^ sclk_d;
   assign lead           = edge_seen & (sclk_now != CPOL_I);
   assign sample         = CPHA_I ? (edge_seen & ~lead) : lead;
   assign change         = edge_seen & ~sample;
   assign link.miso_d    = miso;
   // released as soon as select is seen high; limited by sync delay
   assign link.miso_oe_n = ss_now;

   // -----------------------------------------------------------------
   // byte framing
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state    = state;
      next_bits     = bits;
      next_sh_tx    = sh_tx;
      next_sh_rx    = sh_rx;
      next_rx_data  = RX_DATA_O;
      next_rx_valid = 1'b0;
      next_tx_taken = 1'b0;
      next_miso     = miso;
      if (ss_now)
      begin
         next_state = spt_pkg::SPT_S_IDLE;
         next_bits  = 3'h0;
      end
      else
      begin
         case (state)
            spt_pkg::SPT_S_IDLE:
            begin
               if ((!CPHA_I && ss_d) || (CPHA_I && lead))
               begin
                  next_miso     = TX_DATA_I[7];
                  next_sh_tx    = {TX_DATA_I[6:0], 1'b0};
                  next_tx_taken = 1'b1;
                  next_bits     = 3'h0;
                  next_state    = spt_pkg::SPT_S_ACTIVE;
               end
            end
            spt_pkg::SPT_S_ACTIVE:
            begin
               if (sample)
               begin
                  next_sh_rx = {sh_rx[6:0], mosi_now};
                  next_bits  = bits + 3'h1;
                  if (bits == 3'h7)
                  begin
                     next_rx_data  = {sh_rx[6:0], mosi_now};
                     next_rx_valid = 1'b1;
                     // phase 1 waits for the next first edge, select may stay low
                     next_state    = CPHA_I ? spt_pkg::SPT_S_IDLE
                                            : spt_pkg::SPT_S_DONE;
                  end
               end
               else if (change)
               begin
                  next_miso  = sh_tx[7];
                  next_sh_tx = {sh_tx[6:0], 1'b0};
               end
            end
            spt_pkg::SPT_S_DONE:
            begin
               // extra clocks ignored until select is raised again
               next_state = spt_pkg::SPT_S_DONE;
            end
            default:
            begin
               next_state = spt_pkg::SPT_S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RESETN_I)
      begin
         state      <= spt_pkg::SPT_S_IDLE;
         sync1      <= 3'h4;
         sync2      <= 3'h4;
         sclk_d     <= 1'b0;
         ss_d       <= 1'b1;
         bits       <= 3'h0;
         sh_tx      <= 8'h00;
         sh_rx      <= 8'h00;
         RX_DATA_O  <= 8'h00;
         RX_VALID_O <= 1'b0;
         TX_TAKEN_O <= 1'b0;
         miso       <= 1'b1;
      end
      else
      begin
         state      <= next_state;
         sync1      <= {link.ss_n, link.mosi, link.sclk};
         sync2      <= sync1;
         sclk_d     <= sclk_now;
         ss_d       <= ss_now;
         bits       <= next_bits;
         sh_tx      <= next_sh_tx;
         sh_rx      <= next_sh_rx;
         RX_DATA_O  <= next_rx_data;
         RX_VALID_O <= next_rx_valid;
         TX_TAKEN_O <= next_tx_taken;
         miso       <= next_miso;
      end
   end
endmodule : spt_slave

/* File: tb/spt_chk_sva.sv */
`timescale 1ns/1ps

module spt_chk
(
   input  wire logic CLK_SYS_I,
   input  wire logic RESETN_I,
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic ss_n,
   input  wire logic miso_d,
   input  wire logic miso_oe_n,
   input  wire logic miso
);
   logic [5:0] edges;
   logic [5:0] next_edges;
   logic       sclk_q;

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);

   // ---------------------------------------------------------------
   // link clock edges counted per select window
   // ---------------------------------------------------------------
   always_comb
   begin
      next_edges = edges;
      if (ss_n)
         next_edges = 6'h00;
      else if (sclk != sclk_q)
         next_edges = edges + 6'h01;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      sclk_q <= sclk;
      edges  <= next_edges;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // slave sync chain is two flops deep; the check also accepts three
   chk_miso_sel_only: assert property (!miso_oe_n |-> !$past(ss_n, 2) || !$past(ss_n, 3))
      else $error("miso driven without select");
   chk_miso_idle_off: assert property (ss_n [*4] |-> miso_oe_n && miso)
      else $error("miso not released while deselected");
   chk_miso_release: assert property ($rose(ss_n) |-> ##[1:4] miso_oe_n)
      else $error("miso not released after select rose");
   chk_sel_to_drive: assert property ($fell(ss_n) |-> ##[1:7] !miso_oe_n)
      else $error("slave late to drive after select fell");
   chk_setup_quiet: assert property ($fell(ss_n) |=> $stable(sclk) [*6])
      else $error("clock moved too soon after select fell");
   chk_desel_hold: assert property ($rose(ss_n) |=> ss_n [*7])
      else $error("select high too briefly between bytes");
   chk_half_period: assert property ($changed(sclk) && !ss_n |=> $stable(sclk) [*7])
      else $error("clock half period too short");
   chk_edge_count: assert property ($rose(ss_n) |-> edges[3:0] == 4'h0 && edges != 6'h00)
      else $error("frame not a whole number of bytes");
endmodule : spt_chk

/* File: tb/spt_transfer_format_tb_top.sv */
`timescale 1ns/1ps

module spt_transfer_format_tb_top;
   logic               clk_sys = 1'b0;
   logic               resetn = 1'b0;
   logic               cpol = 1'b0;
   logic               cpha = 1'b0;
   logic               hold_ss = 1'b0;
   logic               own_ss_n = 1'b1;
   logic               tx_valid = 1'b0;
   logic               tx_ready;
   spt_pkg::spt_byte_t tx_data = 8'h00;
   spt_pkg::spt_byte_t m_rx;
   logic               m_rx_v;
   logic               fault;
   spt_pkg::spt_byte_t s_tx = 8'h00;
   logic               s_taken;
   spt_pkg::spt_byte_t s_rx;
   logic               s_rx_v;
   spt_pkg::spt_byte_t m_q[$];
   spt_pkg::spt_byte_t s_q[$];
   int                 rises, takes, faults, cycles, miscompares, n_compared;
   logic               refused;
   logic               busy;

   spt_if spt_if_i();
   spt_master spt_master_i(.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .link(spt_if_i.master),
      .CPOL_I(cpol), .CPHA_I(cpha), .HOLD_SS_I(hold_ss), .OWN_SS_N_I(own_ss_n),
      .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_DATA_I(tx_data), .RX_DATA_O(m_rx),
      .RX_VALID_O(m_rx_v), .BUSY_O(busy), .MODE_FAULT_O(fault));
   spt_slave spt_slave_i(.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .link(spt_if_i.slave),
      .CPOL_I(cpol), .CPHA_I(cpha), .TX_DATA_I(s_tx), .TX_TAKEN_O(s_taken),
      .RX_DATA_O(s_rx), .RX_VALID_O(s_rx_v));
   spt_chk spt_chk_i(.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .sclk(spt_if_i.sclk),
      .mosi(spt_if_i.mosi), .ss_n(spt_if_i.ss_n), .miso_d(spt_if_i.miso_d),
      .miso_oe_n(spt_if_i.miso_oe_n), .miso(spt_if_i.miso));

   always #2.5 clk_sys = ~clk_sys;

   // ---------------------------------------------------------------
   // monitors and watchdog
   // ---------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      cycles++;
      if (m_rx_v === 1'b1) m_q.push_back(m_rx);
      if (s_rx_v === 1'b1) s_q.push_back(s_rx);
      if (s_taken === 1'b1) takes++;
      if (fault === 1'b1) faults++;
      if (tx_valid && tx_ready !== 1'b1) refused = 1'b1;
      if (cycles == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   always @(posedge spt_if_i.ss_n) rises++;

   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // valid stays up across a batch; the caller lowers it
   task automatic push(input spt_pkg::spt_byte_t b);
      tx_valid = 1'b1;
      tx_data  = b;
      while (tx_ready !== 1'b1) step();
      step();
   endtask : push

   task automatic run(input string name, input logic pol, input logic pha, input logic hold,
                      input spt_pkg::spt_byte_t mb[$], input spt_pkg::spt_byte_t sb,
                      input int exp_rises);
      int i;
      cpol    = pol;
      cpha    = pha;
      hold_ss = hold;
      s_tx    = sb;
      m_q.delete();
      s_q.delete();
      rises   = 0;
      takes   = 0;
      faults  = 0;
      refused = 1'b0;
      step();
      check("miso idle", {7'h00, spt_if_i.miso}, 8'h01);
      foreach (mb[k]) push(mb[k]);
      tx_valid = 1'b0;
      // one edge after the last push the first byte has left the queue
      step();
      check("busy", {7'h00, busy}, 8'h01);
      for (i = 0; i < 4000 && !(m_q.size() >= mb.size() && s_q.size() >= mb.size()); i++)
         step();
      repeat (12) step();
      check("idle", {7'h00, busy}, 8'h00);
      foreach (mb[k])
      begin
         check("master rx", m_q[k], sb);
         check("slave rx", s_q[k], mb[k]);
      end
      check("select rises", rises[7:0], exp_rises[7:0]);
      check("slave loads", takes[7:0], 8'(mb.size()));
      $display("test %s done", name);
   endtask : run

   task automatic tally_and_finish();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         run("mode", m[1], m[0], 1'b0, '{8'hA5 ^ 8'(m)}, 8'h3C ^ 8'(m << 4), 1);
         check("no fault", faults[7:0], 8'h00);
      end
      // select held low across bytes
      run("hold", 1'b0, 1'b1, 1'b1, '{8'h81, 8'h7E}, 8'h96, 0);
      hold_ss = 1'b0;
      repeat (20) step();
      check("hold release", rises[7:0], 8'h01);
      // six bytes against a four deep queue; the first leaves at once
      // hold request has no effect in phase 0, select still toggles per byte
      run("burst", 1'b1, 1'b0, 1'b1, '{8'h01, 8'h80, 8'hFF, 8'h00, 8'h5A, 8'hE7},
          8'hC3, 6);
      check("queue refused", {7'h00, refused}, 8'h01);
      own_ss_n = 1'b0;
      run("fault", 1'b0, 1'b0, 1'b0, '{8'h42}, 8'h24, 1);
      check("mode fault", {7'h00, faults != 0}, 8'h01);
      own_ss_n = 1'b1;
      tally_and_finish();
   end
endmodule : spt_transfer_format_tb_top
